// ---- rgbdim_core.sv ----
// Command decoder, gradual current ramp and three-channel modulator
`timescale 1ns/1ps

// Behaviour
// - Ramp moves current stepwise to selected target, one step time per step.
// - A ramp runs between 1 and 30 steps.
// - Output step is clamped to 0..30 whatever software writes.
// - Current command applies new step at once to all three channels.
// - Ramp starts when the triggering byte is acknowledged.
// - Each parameter register loads from its own command, others untouched.
// - Step count is absolute distance of start and target positions.
// - Selector 111 stores step time and starts the ramp.
// - Selector 001 loads the shared peak current step.
// - Selectors 010, 011, 100 load duties of channels one to three.
// - Selector 101 loads upward target, 110 loads downward target.
// - Target values are step positions, not current magnitudes.
// - Five-bit duty, 32 levels, modulation clock about 2.1 kHz.
// - Duty zero keeps the channel off.
// - Duty all ones keeps the channel on; others modulate proportionally.
// - Channels run independently; duty writes never touch the current.
// - Selector 000 shuts down, forcing all currents to zero.
// - Step zero gives no current; steps 30 and 31 give maximum.
module rgbdim_core #(
    parameter int unsigned STEP_UNIT_CYCLES = rgbdim_pkg::STEP_UNIT_CYC,
    parameter int unsigned PWM_TICK_CYCLES  = rgbdim_pkg::PWM_TICK_CYC
) (
    input  wire logic                             clk_sys_i,
    input  wire logic                             rst_b_i,
    input  wire logic                             clk_link_i,
    input  wire logic                             rst_link_b_i,
    input  wire rgbdim_pkg::rgbdim_cmd_t          cmd_byte_i,
    input  wire logic                             cmd_ack_i,
    output logic [rgbdim_pkg::STEP_W-1:0]         led_output_current_o,
    output logic [rgbdim_pkg::NUM_CHAN-1:0]       chan_on_o,
    output logic                                  ramp_busy_o,
    output logic                                  shutdown_o
);
    import rgbdim_pkg::*;

    localparam logic [31:0] UNIT_LAST = 32'(STEP_UNIT_CYCLES - 1);
    localparam logic [31:0] TICK_LAST = 32'(PWM_TICK_CYCLES - 1);

    // Link domain
    rgbdim_cmd_t  link_cmd;
    logic         link_tgl;

    // Crossing and decode
    logic         sync_tgl1;
    logic         sync_tgl2;
    logic         sync_tgl3;
    logic         cmd_evt;
    rgbdim_cmd_t  cmd_sys;

    // Parameter registers
    logic [4:0]   peak_current_step;
    logic [4:0]   ramp_up_target;
    logic [4:0]   ramp_down_target;
    logic [4:0]   ramp_step_time_run;
    logic         dir_up;
    logic [4:0]   duty [NUM_CHAN];

    // Ramp engine
    rgbdim_ramp_t ramp_state;
    logic [4:0]   cur_step;
    logic [4:0]   ramp_end_step;
    logic [4:0]   steps_left;
    logic [31:0]  pre_cnt;
    logic [4:0]   unit_cnt;
    logic [4:0]   step_units;
    logic         unit_done;
    logic         step_tick;
    logic [4:0]   next_step;
    logic [4:0]   run_end;
    logic [4:0]   run_steps;
    logic [4:0]   run_units;
    logic         shutdown;

    // Modulator
    logic [31:0]  pwm_pre;
    logic [4:0]   pwm_cnt;

    default clocking def_clk @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    always_ff @(posedge clk_link_i) begin
        if (!rst_link_b_i) begin
            link_cmd <= CMD_RESET;
            link_tgl <= 1'b0;
        end else if (cmd_ack_i) begin
            link_cmd <= cmd_byte_i;
            link_tgl <= ~link_tgl;
        end
    end

    // Toggle crossing; the byte stays put until the next acknowledge
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sync_tgl1 <= 1'b0;
            sync_tgl2 <= 1'b0;
            sync_tgl3 <= 1'b0;
        end else begin
            sync_tgl1 <= link_tgl;
            sync_tgl2 <= sync_tgl1;
            sync_tgl3 <= sync_tgl2;
        end
    end

    assign cmd_evt = sync_tgl2 ^ sync_tgl3;
    assign cmd_sys = link_cmd;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            peak_current_step <= PEAK_RESET;
        end else if (cmd_evt && cmd_sys.sel == SEL_PEAK) begin
            peak_current_step <= cmd_sys.data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ramp_up_target   <= TGT_RESET;
            ramp_down_target <= TGT_RESET;
            dir_up           <= 1'b1;
        end else if (cmd_evt && cmd_sys.sel == SEL_UP_TGT) begin
            ramp_up_target <= cmd_sys.data;
            dir_up         <= 1'b1;
        end else if (cmd_evt && cmd_sys.sel == SEL_DN_TGT) begin
            ramp_down_target <= cmd_sys.data;
            dir_up           <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ramp_step_time_run <= TIME_RESET;
        end else if (cmd_evt && cmd_sys.sel == SEL_RUN) begin
            ramp_step_time_run <= cmd_sys.data;
        end
    end

    // Shutdown flag; a current or run command wakes the chip
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            shutdown <= 1'b0;
        end else if (cmd_evt) begin
            case (cmd_sys.sel)
                SEL_SHUTDOWN: begin
                    shutdown <= 1'b1;
                end
                SEL_PEAK, SEL_RUN: begin
                    shutdown <= 1'b0;
                end
                default: begin
                    shutdown <= shutdown;
                end
            endcase
        end
    end

    // Targets taken as clamped step positions
    assign run_end   = clamp_step(dir_up ? ramp_up_target : ramp_down_target);
    // Distance between present and target positions
    assign run_steps = step_dist(cur_step, run_end);
    // Time code zero runs as one unit so a step never has zero length
    assign run_units = (cmd_sys.data == STEP_ZERO) ? TIME_MIN : cmd_sys.data;
    assign unit_done = (pre_cnt == UNIT_LAST);
    assign step_tick = (ramp_state == RAMP_RUN) && unit_done
                       && (unit_cnt == 5'(step_units - TIME_MIN));
    // One position toward the end step
    assign next_step = (cur_step < ramp_end_step) ? 5'(cur_step + 5'h01)
                                                  : 5'(cur_step - 5'h01);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ramp_state    <= RAMP_IDLE;
            cur_step      <= STEP_ZERO;
            ramp_end_step <= STEP_ZERO;
            steps_left    <= STEP_ZERO;
            step_units    <= TIME_MIN;
            pre_cnt       <= '0;
            unit_cnt      <= STEP_ZERO;
        end else if (cmd_evt && cmd_sys.sel == SEL_SHUTDOWN) begin
            ramp_state <= RAMP_IDLE;
        end else if (cmd_evt && cmd_sys.sel == SEL_PEAK) begin
            ramp_state <= RAMP_IDLE;
            cur_step   <= clamp_step(cmd_sys.data);
        end else if (cmd_evt && cmd_sys.sel == SEL_RUN) begin
            // No ramp when already at the end step
            ramp_state    <= (run_steps != STEP_ZERO) ? RAMP_RUN : RAMP_IDLE;
            ramp_end_step <= run_end;
            steps_left    <= run_steps;
            step_units    <= run_units;
            pre_cnt       <= '0;
            unit_cnt      <= STEP_ZERO;
        end else begin
            case (ramp_state)
                RAMP_IDLE: begin
                    pre_cnt <= '0;
                end
                RAMP_RUN: begin
                    if (unit_done) begin
                        pre_cnt <= '0;
                    end else begin
                        pre_cnt <= 32'(pre_cnt + 32'h1);
                    end
                    if (step_tick) begin
                        unit_cnt   <= STEP_ZERO;
                        cur_step   <= next_step;
                        steps_left <= 5'(steps_left - 5'h01);
                        if (steps_left == 5'h01) begin
                            ramp_state <= RAMP_IDLE;
                        end
                    end else if (unit_done) begin
                        unit_cnt <= 5'(unit_cnt + 5'h01);
                    end
                end
                default: begin
                    ramp_state <= RAMP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pwm_pre <= '0;
            pwm_cnt <= STEP_ZERO;
        end else if (pwm_pre == TICK_LAST) begin
            pwm_pre <= '0;
            pwm_cnt <= 5'(pwm_cnt + 5'h01);
        end else begin
            pwm_pre <= 32'(pwm_pre + 32'h1);
        end
    end

    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        localparam rgbdim_sel_t CH_SEL = rgbdim_sel_t'(3'(int'(SEL_DUTY1) + ch));

        always_ff @(posedge clk_sys_i) begin
            if (!rst_b_i) begin
                duty[ch] <= DUTY_RESET;
            end else if (cmd_evt && cmd_sys.sel == CH_SEL) begin
                duty[ch] <= cmd_sys.data;
            end
        end

        // Compare counter against duty, full duty stays on
        always_ff @(posedge clk_sys_i) begin
            if (!rst_b_i) begin
                chan_on_o[ch] <= 1'b0;
            end else begin
                chan_on_o[ch] <= !shutdown
                                 && (duty[ch] == DUTY_FULL || pwm_cnt < duty[ch]);
            end
        end

        chk_duty_zero_off: assert property (
            $past(duty[ch]) == DUTY_RESET |-> !chan_on_o[ch]
        ) else $error("channel on with zero duty");

        chk_duty_full_on: assert property (
            $past(duty[ch]) == DUTY_FULL && !$past(shutdown) |-> chan_on_o[ch]
        ) else $error("channel off with full duty");
    end

    // Registered outputs, current forced to zero in shutdown
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            led_output_current_o <= STEP_ZERO;
            ramp_busy_o          <= 1'b0;
            shutdown_o           <= 1'b0;
        end else begin
            led_output_current_o <= shutdown ? STEP_ZERO : clamp_step(cur_step);
            ramp_busy_o          <= (ramp_state == RAMP_RUN);
            shutdown_o           <= shutdown;
        end
    end

    chk_output_clamp: assert property (
        led_output_current_o <= MAX_STEP
    ) else $error("output step above maximum");

    chk_shutdown_zero: assert property (
        cmd_evt && cmd_sys.sel == SEL_SHUTDOWN |-> ##2 led_output_current_o == STEP_ZERO
    ) else $error("current not zero after shutdown");

    chk_peak_apply: assert property (
        cmd_evt && cmd_sys.sel == SEL_PEAK
        |=> cur_step == clamp_step($past(cmd_sys.data)) && ramp_state == RAMP_IDLE
        ##1 led_output_current_o == cur_step
    ) else $error("peak step not applied");

    // Ramp starts on the acknowledged run byte
    chk_ramp_start: assert property (
        cmd_evt && cmd_sys.sel == SEL_RUN && run_steps != STEP_ZERO
        |=> ramp_state == RAMP_RUN && steps_left == $past(run_steps)
        ##1 ramp_busy_o
    ) else $error("ramp did not start");

    chk_step_count: assert property (
        ramp_state == RAMP_RUN |-> steps_left >= 5'h01 && steps_left <= MAX_STEP
    ) else $error("ramp step count out of range");

    // At most one position per step tick, none between ticks
    chk_step_hold: assert property (
        ramp_state == RAMP_RUN && !cmd_evt && !step_tick |=> $stable(cur_step)
    ) else $error("step moved between ticks");

    // Ramp ends on the end step
    chk_ramp_stop: assert property (
        step_tick && steps_left == 5'h01 && !cmd_evt
        |=> ramp_state == RAMP_IDLE && cur_step == ramp_end_step
    ) else $error("ramp did not end on target");

    // Duty writes leave the current alone
    chk_duty_only: assert property (
        cmd_evt && ramp_state == RAMP_IDLE
        && (cmd_sys.sel == SEL_DUTY1 || cmd_sys.sel == SEL_DUTY2 || cmd_sys.sel == SEL_DUTY3)
        |=> $stable(cur_step) && $stable(peak_current_step)
    ) else $error("duty write moved the current");

    chk_target_isolate: assert property (
        cmd_evt && cmd_sys.sel == SEL_UP_TGT
        |=> ramp_up_target == $past(cmd_sys.data) && $stable(ramp_down_target)
            && $stable(ramp_step_time_run) && $stable(peak_current_step)
    ) else $error("target write disturbed another register");

    chk_down_target: assert property (
        cmd_evt && cmd_sys.sel == SEL_DN_TGT
        |=> ramp_down_target == $past(cmd_sys.data) && $stable(ramp_up_target)
    ) else $error("downward target not loaded");

    chk_peak_load: assert property (
        cmd_evt && cmd_sys.sel == SEL_PEAK |=> peak_current_step == $past(cmd_sys.data)
    ) else $error("peak register not loaded");

    chk_time_load: assert property (
        cmd_evt && cmd_sys.sel == SEL_RUN |=> ramp_step_time_run == $past(cmd_sys.data)
    ) else $error("step time not loaded");

    chk_step_unit: assert property (
        step_tick && !cmd_evt
        |=> cur_step == 5'($past(cur_step) + 5'h01) || cur_step == 5'($past(cur_step) - 5'h01)
    ) else $error("ramp moved more than one position");

    chk_shutdown_dark: assert property (
        shutdown_o |-> chan_on_o == '0
    ) else $error("channel on during shutdown");

endmodule : rgbdim_core

// ---- rgbdim_pkg.sv ----
// Shared constants, command encoding and carrier types of the RGB dimming core
package rgbdim_pkg;

    // Command selector held in the upper three bits of a command byte
    typedef enum logic [2:0] {
        SEL_SHUTDOWN = 3'b000,
        SEL_PEAK     = 3'b001,
        SEL_DUTY1    = 3'b010,
        SEL_DUTY2    = 3'b011,
        SEL_DUTY3    = 3'b100,
        SEL_UP_TGT   = 3'b101,
        SEL_DN_TGT   = 3'b110,
        SEL_RUN      = 3'b111
    } rgbdim_sel_t;

    // One command byte as acknowledged by the serial decoder
    typedef struct packed {
        rgbdim_sel_t sel;
        logic [4:0]  data;
    } rgbdim_cmd_t;

    typedef enum logic {
        RAMP_IDLE = 1'b0,
        RAMP_RUN  = 1'b1
    } rgbdim_ramp_t;

    localparam int          STEP_W      = 5;
    localparam int          NUM_CHAN    = 3;
    localparam rgbdim_cmd_t CMD_RESET   = '{sel: SEL_SHUTDOWN, data: 5'h00};

    // Step positions on the current scale, full duty code and minimum step time
    localparam logic [4:0]  STEP_ZERO   = 5'h00;
    localparam logic [4:0]  MAX_STEP    = 5'h1e;
    localparam logic [4:0]  DUTY_FULL   = 5'h1f;
    localparam logic [4:0]  TIME_MIN    = 5'h01;

    // Reset values of the parameter registers
    localparam logic [4:0]  PEAK_RESET  = 5'h00;
    localparam logic [4:0]  DUTY_RESET  = 5'h00;
    localparam logic [4:0]  TGT_RESET   = 5'h00;
    localparam logic [4:0]  TIME_RESET  = 5'h01;

    // Timing: system clock, per-step time unit and modulation clock
    localparam int CLK_PERIOD_NS  = 5;
    localparam int STEP_UNIT_MS   = 8;
    localparam int PWM_CLK_HZ     = 2100;
    localparam int STEP_UNIT_CYC  = STEP_UNIT_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int PWM_TICK_CYC   = 1_000_000_000 / (PWM_CLK_HZ * CLK_PERIOD_NS);

    // Step positions 30 and 31 give the same current
    function automatic logic [4:0] clamp_step(input logic [4:0] s);
        return (s > MAX_STEP) ? MAX_STEP : s;
    endfunction : clamp_step

    function automatic logic [4:0] step_dist(input logic [4:0] a, input logic [4:0] b);
        return (a > b) ? 5'(a - b) : 5'(b - a);
    endfunction : step_dist

endpackage : rgbdim_pkg

// ---- rgbdim_mcu_model.sv ----
// Microcontroller model: write-only serial frames delivering command bytes
`timescale 1ns/1ps
module rgbdim_mcu_model (
    output logic                    clk_link_o,
    output rgbdim_pkg::rgbdim_cmd_t cmd_byte_o,
    output logic                    cmd_ack_o
);
    import rgbdim_pkg::*;

    initial begin
        clk_link_o = 1'b0;
        cmd_byte_o = '0;
        cmd_ack_o  = 1'b0;
    end

    // Link clock runs only when pulsed: while a frame is on the wire, and during reset
    task automatic pulse(input int n);
        repeat (n) begin
            #6 clk_link_o = 1'b1;
            #6 clk_link_o = 1'b0;
        end
    endtask : pulse

    task automatic send(input logic [7:0] b);
        pulse(17);
        cmd_byte_o = b;
        cmd_ack_o  = 1'b1;
        pulse(1);
        cmd_ack_o  = 1'b0;
        // Byte no longer held: show a changed value
        cmd_byte_o = ~b;
    endtask : send
endmodule : rgbdim_mcu_model

// ---- tb_top.sv ----
// Self-checking testbench of the RGB dimming core
`timescale 1ns/1ps
module tb_top;
    import rgbdim_pkg::*;
    localparam int UNIT = 4;
    localparam int TICK = 2;

    logic        clk_sys_i;
    logic        rst_b_i;
    logic        rst_link_b_i;
    logic        clk_link_i;
    logic        cmd_ack_i;
    rgbdim_cmd_t cmd_byte_i;
    logic [4:0]  led_output_current_o;
    logic [2:0]  chan_on_o;
    logic        ramp_busy_o;
    logic        shutdown_o;
    int          err_count;
    int          samples_checked;
    logic [31:0] lfsr_state;
    logic [15:0] exp_q[$];
    logic [4:0]  last_led;
    int          gap_cnt;
    logic [15:0] note;
    logic [4:0]  duty [3];
    int          on_cnt [3];

    rgbdim_core #(.STEP_UNIT_CYCLES(UNIT), .PWM_TICK_CYCLES(TICK)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_link_i(clk_link_i),
        .rst_link_b_i(rst_link_b_i), .cmd_byte_i(cmd_byte_i), .cmd_ack_i(cmd_ack_i),
        .led_output_current_o(led_output_current_o), .chan_on_o(chan_on_o),
        .ramp_busy_o(ramp_busy_o), .shutdown_o(shutdown_o));

    rgbdim_mcu_model u_mcu (
        .clk_link_o(clk_link_i), .cmd_byte_o(cmd_byte_i), .cmd_ack_o(cmd_ack_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] lfsr_next();
        lfsr_state = {lfsr_state[30:0],
                      lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state;
    endfunction : lfsr_next

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic push(input int s, input int gap);
        exp_q.push_back({11'(gap), 5'(s)});
    endtask : push

    // Notes every step after the start, end step included; the first step's delay is not pinned down
    task automatic ramp(input int a, input int b, input int gap);
        int s;
        s = a;
        while (s != b) begin
            s += (b > a) ? 1 : -1;
            push(s, (s == a || (s - a == 1) || (a - s == 1)) ? 0 : gap);
        end
    endtask : ramp

    task automatic cmd(input logic [7:0] b);
        @(posedge clk_sys_i);
        #1;
        u_mcu.send(b);
    endtask : cmd

    task automatic settle();
        int n;
        n = 0;
        repeat (12) @(posedge clk_sys_i);
        while ((ramp_busy_o !== 1'b0 || exp_q.size() != 0) && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        check(16'(exp_q.size()), 16'h0000);
        check({15'h0, ramp_busy_o}, 16'h0000);
        repeat (4) @(posedge clk_sys_i);
    endtask : settle

    // Output watcher: every change of the current step takes the oldest note
    always @(posedge clk_sys_i) begin
        if (rst_b_i !== 1'b1) begin
            last_led = '0;
            gap_cnt  = 0;
        end else begin
            gap_cnt++;
            if (led_output_current_o !== last_led) begin
                note = (exp_q.size() == 0) ? {11'h0, ~led_output_current_o} : exp_q.pop_front();
                check({11'h0, led_output_current_o}, {11'h0, note[4:0]});
                if (note[15:5] != 11'h0) begin
                    check(16'(gap_cnt), {5'h0, note[15:5]});
                end
                last_led = led_output_current_o;
                gap_cnt  = 0;
            end
        end
    end

    initial begin
        #(60000 * 5);
        err_count++;
        summarize();
    end

    initial begin
        int n;
        int r;
        err_count       = 0;
        samples_checked = 0;
        lfsr_state      = 32'h746ec53e;
        rst_b_i         = 1'b0;
        rst_link_b_i    = 1'b0;
        fork
            u_mcu.pulse(2);
            repeat (3) @(posedge clk_sys_i);
        join
        @(posedge clk_sys_i);
        #1;
        rst_b_i      = 1'b1;
        rst_link_b_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        check({6'h0, led_output_current_o, chan_on_o, ramp_busy_o, shutdown_o}, 16'h0);
        push(15, 0);
        cmd(8'h2f);
        settle();
        push(30, 0);
        cmd(8'h3f);
        settle();
        for (r = 0; r < 3; r++) begin
            for (int k = 0; k < 3; k++) begin
                duty[k] = (r == 0 && k < 2) ? ((k == 0) ? 5'h00 : 5'h1f)
                                            : 5'(lfsr_next());
                cmd({3'(k + 2), duty[k]});
            end
            repeat (8) @(posedge clk_sys_i);
            on_cnt = '{0, 0, 0};
            repeat (32 * TICK) begin
                @(posedge clk_sys_i);
                for (int k = 0; k < 3; k++) on_cnt[k] += (chan_on_o[k] === 1'b1) ? 1 : 0;
            end
            for (int k = 0; k < 3; k++) begin
                check(16'(on_cnt[k]), 16'(TICK * ((duty[k] == 5'h1f) ? 32 : duty[k])));
            end
        end
        push(5, 0);
        cmd(8'h25);
        settle();
        cmd(8'hb0);
        ramp(5, 16, 3 * UNIT);
        cmd(8'he3);
        n = 0;
        while (ramp_busy_o !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            n++;
        end
        check({15'h0, ramp_busy_o}, 16'h0001);
        settle();
        cmd(8'hc1);
        ramp(16, 1, UNIT);
        cmd(8'he1);
        settle();
        cmd(8'hbf);
        cmd(8'hff);
        push(0, 0);
        cmd(8'h00);
        repeat (8) @(posedge clk_sys_i);
        check({14'h0, ramp_busy_o, shutdown_o}, 16'h0001);
        n = 0;
        repeat (32 * TICK) begin
            @(posedge clk_sys_i);
            n += (chan_on_o !== 3'b000) ? 1 : 0;
        end
        check(16'(n), 16'h0000);
        cmd(8'ha4);
        push(1, 0);
        ramp(1, 4, 2 * UNIT);
        cmd(8'he2);
        settle();
        push(0, 0);
        cmd(8'h20);
        settle();
        cmd(8'hbe);
        ramp(0, 30, UNIT);
        cmd(8'he1);
        settle();
        cmd(8'he1);
        n = 0;
        repeat (20) begin
            @(posedge clk_sys_i);
            n += (ramp_busy_o !== 1'b0) ? 1 : 0;
        end
        check(16'(n), 16'h0000);
        settle();
        summarize();
    end
endmodule : tb_top
